// ---- verilog/wcb_top.sv ----
// Write-combining buffer set between the store pipeline and memory fabric.
// Assumes the pipeline holds a request until it is accepted and the
// fabric takes one write per cycle when it raises its ready.
//
// Notes on behaviour
// - Each buffer owns one aligned 64-byte line; later stores merge.
// - Byte, word, doubleword and quadword stores land at their offset.
// - Combinable stores merge in any order until the line is full.
// - Other memory types bypass; streaming write-back stores combine.
// - Streaming buffers close on the same events as combinable ones.
// - Partially filled buffers may stay open until an event.
// - Closing a buffer also flushes every older buffer.
// - Port input or output closes combining and never merges.
// - Any serializing operation closes combining.
// - Line flush closes only for combinable or uncached lines.
// - Lock start closes combining; stores inside the lock still merge.
// - Uncached read closes; combinable read closes on a line match.
// - A store of different memory type hitting a buffer closes it.
// - A buffer closes once all 64 bytes are valid.
// - A table walk setting accessed or dirty bits closes combining.
// - Store or memory fence drains every combining buffer.
// - Interrupts and exceptions drain all buffers before the handler.
// - A fully valid buffer goes out as one 64-byte write.
// - At most 8 buffers, no more than 7 held by one thread.
module wcb_top
  import wcb_pkg::*;
(
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      st_valid_in,
  output logic                           st_ready_out,
  input  wire logic [WCB_ADDR_W-1:0]     st_addr_in,
  input  wire logic [1:0]                st_size_in,
  input  wire logic [63:0]               st_data_in,
  input  wire logic [2:0]                st_mtype_in,
  input  wire logic                      st_stream_in,
  input  wire logic                      st_thread_in,
  input  wire logic                      ev_port_io_in,
  input  wire logic                      ev_serialize_in,
  input  wire logic                      ev_line_flush_in,
  input  wire logic [2:0]                ev_flush_mtype_in,
  input  wire logic                      ev_lock_start_in,
  input  wire logic                      ev_read_in,
  input  wire logic [WCB_ADDR_W-1:0]     ev_read_addr_in,
  input  wire logic [2:0]                ev_read_mtype_in,
  input  wire logic                      ev_ad_bit_set_in,
  input  wire logic                      ev_fence_in,
  input  wire logic                      ev_interrupt_in,
  output logic                           drained_out,
  output logic                           wr_valid_out,
  input  wire logic                      wr_ready_in,
  output logic [WCB_TAG_W-1:0]           wr_line_out,
  output logic [WCB_LINE_BYTES-1:0]      wr_mask_out,
  output logic [511:0]                   wr_data_out,
  output logic                           wr_full_line_out
);

  // ==========================================================================
  // Flush state machine.
  typedef enum logic [1:0] {
    WCB_ST_IDLE  = 2'b01,
    WCB_ST_DRAIN = 2'b10
  } wcb_state_e;

  wcb_state_e                     state_reg;
  logic [WCB_NUM_BUF-1:0]         busy;
  logic [WCB_TAG_W-1:0]           tag    [WCB_NUM_BUF];
  logic [2:0]                     mtype  [WCB_NUM_BUF];
  logic [WCB_NUM_BUF-1:0]         thr;
  logic [WCB_LINE_BYTES-1:0]      mask   [WCB_NUM_BUF];
  logic [511:0]                   data   [WCB_NUM_BUF];
  logic [WCB_AGE_W-1:0]           age_reg [WCB_NUM_BUF];
  logic [WCB_NUM_BUF-1:0]         close_reg;
  logic [WCB_NUM_BUF-1:0]         alloc;
  logic [WCB_NUM_BUF-1:0]         merge;
  logic [WCB_NUM_BUF-1:0]         release_v;
  logic [WCB_NUM_BUF-1:0]         hit;
  logic [WCB_NUM_BUF-1:0]         rd_hit;
  logic [WCB_NUM_BUF-1:0]         close_next;
  logic [WCB_TAG_W-1:0]           st_tag;
  logic [WCB_LINE_BYTES-1:0]      st_be;
  logic [511:0]                   st_line;
  logic                           st_comb;
  logic                           any_hit;
  logic                           mt_clash;
  logic                           free_any;
  logic [WCB_IDX_W-1:0]           free_idx;
  logic [3:0]                     thr_cnt;
  logic                           close_all;
  logic [WCB_AGE_W-1:0]           clash_age;
  logic                           pick_ok;
  logic [WCB_IDX_W-1:0]           pick_idx;
  logic [WCB_AGE_W-1:0]           n_busy;
  logic [WCB_NUM_BUF-1:0]         age_zero;

  // ==========================================================================
  // Buffer slots.
  for (genvar g = 0; g < WCB_NUM_BUF; g++) begin : g_slot
    wcb_slot u_slot (
      .clock_in   (clock_in),
      .rst_n_in   (rst_n_in),
      .alloc_in   (alloc[g]),
      .merge_in   (merge[g]),
      .release_in (release_v[g]),
      .tag_in     (st_tag),
      .mtype_in   (st_mtype_in),
      .thread_in  (st_thread_in),
      .be_in      (st_be),
      .data_in    (st_line),
      .busy_out   (busy[g]),
      .tag_out    (tag[g]),
      .mtype_out  (mtype[g]),
      .thread_out (thr[g]),
      .mask_out   (mask[g]),
      .data_out   (data[g])
    );
  end

  // ==========================================================================
  // Store decode: place data at its byte offset within the line.
  always_comb begin
    logic [7:0] sz_be;
    sz_be = 8'h01;
    unique case (st_size_in)
      WCB_SIZE_BYTE:  sz_be = 8'h01;
      WCB_SIZE_WORD:  sz_be = 8'h03;
      WCB_SIZE_DWORD: sz_be = 8'h0f;
      WCB_SIZE_QWORD: sz_be = 8'hff;
    endcase
    st_tag  = st_addr_in[WCB_ADDR_W-1:WCB_OFS_W];
    st_be   = WCB_LINE_BYTES'({56'h0, sz_be} << st_addr_in[5:0]);
    st_line = 512'({448'h0, st_data_in} << {st_addr_in[5:0], 3'h0});
    // Streaming overrides write-back and combines like combinable memory.
    st_comb = (st_mtype_in == WCB_MT_COMBINABLE) ||
              (st_stream_in && (st_mtype_in == WCB_MT_WRITE_BACK));
  end

  // Hit, clash and read-match detection.
  always_comb begin
    for (int i = 0; i < WCB_NUM_BUF; i++) begin
      hit[i]    = busy[i] && !close_reg[i] && (tag[i] == st_tag);
      rd_hit[i] = busy[i] &&
                  (tag[i] == ev_read_addr_in[WCB_ADDR_W-1:WCB_OFS_W]);
    end
    any_hit = |hit;
    mt_clash = 1'b0;
    for (int i = 0; i < WCB_NUM_BUF; i++) begin
      if (hit[i] && (mtype[i] != st_mtype_in || !st_comb)) begin
        mt_clash = 1'b1;
      end
    end
  end

  // Free slot search and per-thread occupancy.
  always_comb begin
    free_any = 1'b0;
    free_idx = '0;
    thr_cnt  = 4'h0;
    n_busy   = '0;
    for (int i = WCB_NUM_BUF - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        free_any = 1'b1;
        free_idx = WCB_IDX_W'(i);
      end
    end
    for (int i = 0; i < WCB_NUM_BUF; i++) begin
      if (busy[i] && thr[i] == st_thread_in) begin
        thr_cnt = thr_cnt + 4'h1;
      end
      if (busy[i]) begin
        n_busy = n_busy + WCB_AGE_W'(1);
      end
    end
  end

  // ==========================================================================
  // Store acceptance: merge, allocate or pass a non-combining store away.
  // A store that must wait for a closing buffer stalls the pipeline.
  always_comb begin
    alloc = '0;
    merge = '0;
    st_ready_out = 1'b0;
    if (st_comb && !mt_clash) begin
      if (any_hit) begin
        merge = hit & {WCB_NUM_BUF{st_valid_in}};
        st_ready_out = 1'b1;
      end else if (free_any && thr_cnt < 4'(WCB_MAX_PER_THR)) begin
        alloc[free_idx] = st_valid_in;
        st_ready_out = 1'b1;
      end
    end else if (!st_comb) begin
      // Non-combining stores are not held here.
      st_ready_out = !mt_clash;
    end
  end

  // ==========================================================================
  // Allocation age: zero is oldest; releases shift younger ones down.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < WCB_NUM_BUF; i++) begin
        age_reg[i] <= WCB_AGE_RST;
      end
    end else begin
      for (int i = 0; i < WCB_NUM_BUF; i++) begin
        if (alloc[i]) begin
          age_reg[i] <= n_busy - WCB_AGE_W'(|release_v);
        end else if (busy[i] && |release_v &&
                     age_reg[i] > age_reg[pick_idx]) begin
          age_reg[i] <= age_reg[i] - WCB_AGE_W'(1);
        end
      end
    end
  end

  // ==========================================================================
  // Completion events close buffers; partial buffers otherwise stay open.
  always_comb begin
    close_all = ev_port_io_in
             || ev_serialize_in
             || (ev_line_flush_in &&
                 (ev_flush_mtype_in == WCB_MT_COMBINABLE ||
                  ev_flush_mtype_in == WCB_MT_UNCACHED))
             || ev_lock_start_in
             || (ev_read_in &&
                 ev_read_mtype_in == WCB_MT_UNCACHED)
             || ev_ad_bit_set_in
             || ev_fence_in
             || ev_interrupt_in;
    clash_age = '0;
    close_next = close_reg;
    for (int i = 0; i < WCB_NUM_BUF; i++) begin
      if (busy[i] && close_all) begin
        close_next[i] = 1'b1;
      end
      if (ev_read_in && ev_read_mtype_in == WCB_MT_COMBINABLE &&
          rd_hit[i]) begin
        close_next[i] = 1'b1;
      end
      if (st_valid_in && hit[i] && mt_clash) begin
        close_next[i] = 1'b1;
      end
      if (busy[i] && (mask[i] | (merge[i] ? st_be : '0)) == '1) begin
        close_next[i] = 1'b1;
      end
    end
    // Anything older than a closing buffer closes with it.
    for (int i = 0; i < WCB_NUM_BUF; i++) begin
      if (close_next[i] && busy[i] && age_reg[i] > clash_age) begin
        clash_age = age_reg[i];
      end
    end
    for (int i = 0; i < WCB_NUM_BUF; i++) begin
      if (busy[i] && |close_next && age_reg[i] <= clash_age) begin
        close_next[i] = 1'b1;
      end
      if (release_v[i] || !busy[i]) begin
        close_next[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      close_reg <= '0;
    end else begin
      close_reg <= close_next;
    end
  end

  // ==========================================================================
  // Oldest closed buffer is picked for the fabric.
  always_comb begin
    pick_ok  = 1'b0;
    pick_idx = '0;
    for (int i = 0; i < WCB_NUM_BUF; i++) begin
      age_zero[i] = busy[i] && (age_reg[i] == WCB_AGE_RST);
      if (busy[i] && close_reg[i] && age_reg[i] == WCB_AGE_RST) begin
        pick_ok  = 1'b1;
        pick_idx = WCB_IDX_W'(i);
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= WCB_ST_IDLE;
    end else begin
      unique case (state_reg)
        WCB_ST_IDLE:  state_reg <= pick_ok ? WCB_ST_DRAIN : WCB_ST_IDLE;
        WCB_ST_DRAIN: state_reg <= (wr_ready_in && !pick_ok) ?
                                   WCB_ST_IDLE : WCB_ST_DRAIN;
        default:      state_reg <= WCB_ST_IDLE;
      endcase
    end
  end

  // Write port registers hold the picked buffer's line and valid bytes.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_valid_out     <= 1'b0;
      wr_line_out      <= '0;
      wr_mask_out      <= WCB_MASK_RST;
      wr_data_out      <= '0;
      wr_full_line_out <= 1'b0;
    end else if (!wr_valid_out || wr_ready_in) begin
      wr_valid_out     <= pick_ok;
      wr_line_out      <= tag[pick_idx];
      wr_mask_out      <= mask[pick_idx];
      wr_data_out      <= data[pick_idx];
      wr_full_line_out <= (mask[pick_idx] == '1);
    end
  end

  always_comb begin
    release_v = '0;
    if (pick_ok && (!wr_valid_out || wr_ready_in)) begin
      release_v[pick_idx] = 1'b1;
    end
  end

  assign drained_out = (busy == '0) && (state_reg == WCB_ST_IDLE);

  // ==========================================================================
  // Checks.
  default clocking chk_cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_fence;
    ev_fence_in && busy != '0 && alloc == '0;
  endsequence

  AST_FULL_CLOSES: assert property (
    (busy[0] && mask[0] == '1) |=> close_reg[0] || !busy[0])
    else $error("Full buffer not closed.");

  AST_FENCE_CLOSES: assert property (
    s_fence |=> (close_reg == busy))
    else $error("Fence did not close every buffer.");

  AST_MAX_BUFS: assert property (
    (thr_cnt >= 4'(WCB_MAX_PER_THR)) |-> alloc == '0)
    else $error("Thread exceeded its buffer share.");

  AST_NO_UC_MERGE: assert property (
    (st_mtype_in == WCB_MT_UNCACHED) |-> (alloc | merge) == '0)
    else $error("Uncached store was combined.");

  AST_OLDEST_FIRST: assert property (
    (|release_v) |-> age_zero == release_v)
    else $error("Released buffer is not the only oldest one.");

  AST_FULL_FLAG: assert property (
    wr_valid_out && wr_full_line_out |-> wr_mask_out == '1)
    else $error("Full-line write with missing bytes.");

  AST_IO_CLOSES: assert property (
    (ev_port_io_in && busy[0] && !release_v[0]) |=> close_reg[0])
    else $error("Port access did not close combining.");

  AST_WB_BYPASS: assert property (
    (st_mtype_in == WCB_MT_WRITE_BACK && !st_stream_in) |->
      (alloc | merge) == '0)
    else $error("Write-back store was combined.");

endmodule

// ---- verilog/wcb_pkg.sv ----
// Constants and types shared by the write-combining buffer design.
// Assumes a single core clock and an active-low asynchronous reset.
package wcb_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned WCB_NUM_BUF     = 8;
  localparam int unsigned WCB_MAX_PER_THR = 7;
  localparam int unsigned WCB_LINE_BYTES  = 64;
  localparam int unsigned WCB_ADDR_W      = 48;
  localparam int unsigned WCB_OFS_W       = 6;
  localparam int unsigned WCB_TAG_W       = WCB_ADDR_W - WCB_OFS_W;
  localparam int unsigned WCB_IDX_W       = 3;
  localparam int unsigned WCB_AGE_W       = 3;
  localparam int unsigned WCB_CHUNK_BYTES = 16;

  // ==========================================================================
  // Store size codes.
  localparam logic [1:0] WCB_SIZE_BYTE  = 2'h0;
  localparam logic [1:0] WCB_SIZE_WORD  = 2'h1;
  localparam logic [1:0] WCB_SIZE_DWORD = 2'h2;
  localparam logic [1:0] WCB_SIZE_QWORD = 2'h3;

  // ==========================================================================
  // Memory type codes.
  typedef enum logic [2:0] {
    WCB_MT_UNCACHED      = 3'h0,
    WCB_MT_COMBINABLE    = 3'h1,
    WCB_MT_WRITE_THROUGH = 3'h4,
    WCB_MT_PROTECTED     = 3'h5,
    WCB_MT_WRITE_BACK    = 3'h6
  } wcb_memtype_e;

  // ==========================================================================
  // Reset values.
  localparam logic [WCB_LINE_BYTES-1:0] WCB_MASK_RST = 64'h0;
  localparam logic [WCB_AGE_W-1:0]      WCB_AGE_RST  = 3'h0;

endpackage

// ---- verilog/wcb_slot.sv ----
// One combining buffer slot: line tag, per-byte data and valid mask.
// Assumes the parent decides allocation, merging and release.
module wcb_slot
  import wcb_pkg::*;
(
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      alloc_in,
  input  wire logic                      merge_in,
  input  wire logic                      release_in,
  input  wire logic [WCB_TAG_W-1:0]      tag_in,
  input  wire logic [2:0]                mtype_in,
  input  wire logic                      thread_in,
  input  wire logic [WCB_LINE_BYTES-1:0] be_in,
  input  wire logic [511:0]              data_in,
  output logic                           busy_out,
  output logic [WCB_TAG_W-1:0]           tag_out,
  output logic [2:0]                     mtype_out,
  output logic                           thread_out,
  output logic [WCB_LINE_BYTES-1:0]      mask_out,
  output logic [511:0]                   data_out
);

  // ==========================================================================
  // Slot state.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out   <= 1'b0;
      tag_out    <= '0;
      mtype_out  <= 3'h0;
      thread_out <= 1'b0;
    end else if (alloc_in) begin
      busy_out   <= 1'b1;
      tag_out    <= tag_in;
      mtype_out  <= mtype_in;
      thread_out <= thread_in;
    end else if (release_in) begin
      busy_out   <= 1'b0;
    end
  end

  // Byte lanes merge in any order; the mask records what is held.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_out <= WCB_MASK_RST;
      data_out <= '0;
    end else if (alloc_in || merge_in) begin
      for (int i = 0; i < WCB_LINE_BYTES; i++) begin
        if (be_in[i]) begin
          data_out[i*8 +: 8] <= data_in[i*8 +: 8];
        end
      end
      mask_out <= (alloc_in ? be_in : (mask_out | be_in));
    end else if (release_in) begin
      mask_out <= WCB_MASK_RST;
    end
  end

endmodule

// ---- tb/wcb_fabric_model.sv ----
// Memory fabric model that takes one line write per ready cycle.
// Assumes the bench hands it a random stall bit every cycle.
module wcb_fabric_model (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic stall_in,
  input  wire logic wr_valid_in,
  output logic      wr_ready_out,
  output logic      take_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Ready is the inverted stall bit a cycle later, so writes may wait.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ready_out <= 1'b0;
    end else begin
      wr_ready_out <= !stall_in;
    end
  end
  assign take_out = wr_valid_in && wr_ready_out;
endmodule

// ---- tb/test_write_combining_buffer.sv ----
// Self-checking bench for the write-combining buffer set.
// Assumes the design package and the fabric model are compiled first.
module test_write_combining_buffer
  import wcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals and reference model.
  logic                  clock_in = 1'b0;
  logic                  rst_n_in = 1'b0;
  logic                  st_valid_in, st_stream_in, st_thread_in, stall;
  logic [WCB_ADDR_W-1:0] st_addr_in, ev_read_addr_in;
  logic [1:0]            st_size_in;
  logic [63:0]           st_data_in, wr_mask_out;
  logic [2:0]            st_mtype_in, ev_flush_mtype_in, ev_read_mtype_in;
  logic [7:0]            ev;
  logic                  st_ready_out, drained_out, wr_valid_out, take;
  logic                  wr_ready_in, wr_full_line_out;
  logic [WCB_TAG_W-1:0]  wr_line_out;
  logic [511:0]          wr_data_out;
  logic [63:0]           em_mask [64];
  logic [511:0]          em_data [64];
  logic [31:0]           seed = 32'h33;
  int                    pend[$], expq[$];
  int                    lid, fail_count, total_checks;
  bit                    ok;
  // Event bit, memory type and whether it closes combining.
  int ev_bit [12] = '{0, 1, 2, 2, 2, 3, 4, 4, 4, 5, 6, 7};
  int ev_mt [12]  = '{0, 0, 6, 1, 0, 0, 0, 1, 1, 0, 0, 0};
  bit ev_cl [12]  = '{1, 1, 0, 1, 1, 1, 1, 0, 1, 1, 1, 1};

  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) stall <= (rnd() & 32'h3) == 32'h0;

  wcb_top i_wcb_top (
    .clock_in, .rst_n_in, .st_valid_in, .st_ready_out, .st_addr_in,
    .st_size_in, .st_data_in, .st_mtype_in, .st_stream_in, .st_thread_in,
    .ev_port_io_in(ev[0]), .ev_serialize_in(ev[1]), .ev_line_flush_in(ev[2]),
    .ev_flush_mtype_in, .ev_lock_start_in(ev[3]), .ev_read_in(ev[4]),
    .ev_read_addr_in, .ev_read_mtype_in, .ev_ad_bit_set_in(ev[5]),
    .ev_fence_in(ev[6]), .ev_interrupt_in(ev[7]), .drained_out,
    .wr_valid_out, .wr_ready_in, .wr_line_out, .wr_mask_out, .wr_data_out,
    .wr_full_line_out
  );
  wcb_fabric_model i_wcb_fabric_model (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .stall_in(stall),
    .wr_valid_in(wr_valid_out), .wr_ready_out(wr_ready_in), .take_out(take)
  );
  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [511:0] wide(logic [63:0] m);
    logic [511:0] w;
    for (int b = 0; b < 64; b++) w[8*b +: 8] = {8{m[b]}};
    return w;
  endfunction

  function automatic void flush();
    while (pend.size() > 0) expq.push_back(pend.pop_front());
  endfunction

  task automatic check(string what, logic [511:0] exp, logic [511:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic store(int id, int ofs, int sz, int mt, logic strm,
                       logic thr, int lim);
    logic [63:0] d;
    bit          hit;
    d = {rnd(), rnd()};
    hit = 1'b0;
    @(posedge clock_in);
    st_valid_in  <= 1'b1;
    st_addr_in   <= {42'(id + 256), 6'(ofs)};
    st_size_in   <= 2'(sz);
    st_data_in   <= d;
    st_mtype_in  <= 3'(mt);
    st_stream_in <= strm;
    st_thread_in <= thr;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge clock_in);
      ok = st_ready_out === 1'b1;
    end
    @(posedge clock_in);
    st_valid_in <= 1'b0;
    foreach (pend[k]) if (pend[k] == id) hit = 1'b1;
    if (lim > 30) check("store taken", 512'(1), 512'(ok));
    if (!ok) return;
    if (mt == 1 || (mt == 6 && strm)) begin
      if (!hit) pend.push_back(id);
      for (int b = 0; b < (1 << sz); b++) begin
        em_mask[id][ofs + b] = 1'b1;
        em_data[id][8*(ofs + b) +: 8] = d[8*b +: 8];
      end
      if (&em_mask[id]) flush();
    end else if (hit) flush();
  endtask

  task automatic pulse(int b, int mt, int rid);
    @(posedge clock_in);
    ev                <= 8'(1 << b);
    ev_flush_mtype_in <= 3'(mt);
    ev_read_mtype_in  <= 3'(mt);
    ev_read_addr_in   <= {42'(rid + 256), 6'h05};
    @(posedge clock_in);
    ev <= 8'h00;
  endtask

  task automatic settle();
    for (int i = 0; i < 400 && expq.size() > 0; i++) @(negedge clock_in);
    repeat (8) @(negedge clock_in);
    check("writes left", 512'(0), 512'(expq.size()));
    if (pend.size() == 0) check("drained", 512'(1), 512'(drained_out));
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Write checker.
  always @(negedge clock_in) begin
    int cid;
    if (rst_n_in && take === 1'b1) begin
      if (expq.size() == 0) begin
        check("stray write", 512'(0), 512'(1));
      end else begin
        cid = expq.pop_front();
        check("line", 512'(cid + 256), 512'(wr_line_out));
        check("mask", 512'(em_mask[cid]), 512'(wr_mask_out));
        check("data", em_data[cid] & wide(em_mask[cid]),
              wr_data_out & wide(em_mask[cid]));
        check("full", 512'(&em_mask[cid]),
              512'(wr_full_line_out));
      end
    end
  end
  // ==========================================================================
  // Scenarios.
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] r;
    st_valid_in = 1'b0;
    st_stream_in = 1'b0;
    st_thread_in = 1'b0;
    st_addr_in = 48'h0;
    st_size_in = 2'h0;
    st_data_in = 64'h0;
    st_mtype_in = 3'h0;
    ev = 8'h00;
    ev_flush_mtype_in = 3'h0;
    ev_read_mtype_in = 3'h0;
    ev_read_addr_in = 48'h0;
    foreach (em_mask[i]) em_mask[i] = 64'h0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int q = 0; q < 8; q++)
      store(0, (q * 5 % 8) * 8, 3, 1, 1'b0, 1'b0, 100);
    settle();
    store(1, 3, 0, 1, 1'b0, 1'b0, 100);
    store(1, 8, 2, 0, 1'b0, 1'b0, 100);
    settle();
    store(2, 0, 3, 6, 1'b0, 1'b1, 100);
    for (int m = 4; m < 6; m++)
      store(2, 8 * m, 3, m, 1'b0, 1'b1, 100);
    settle();
    lid = 3;
    for (int c = 0; c < 12; c++) begin
      for (int k = 0; k < 6; k++) begin
        r = rnd();
        store(lid + k / 3, int'(r[7:2]) & ~((1 << r[1:0]) - 1), r[1:0],
              c[0] ? 6 : 1, c[0], 1'(k / 3), 100);
      end
      pulse(ev_bit[c], ev_mt[c], c == 8 ? lid + 1 : 63);
      lid += 2;
      if (ev_cl[c]) flush();
      settle();
    end
    for (int i = 0; i < 7; i++) store(lid + i, 0, 3, 1, 1'b0, 1'b0, 100);
    store(lid + 7, 0, 3, 1, 1'b0, 1'b0, 30);
    check("thread limit", 512'(0), 512'(ok));
    store(lid + 8, 0, 3, 1, 1'b0, 1'b1, 100);
    check("other thread", 512'(1), 512'(ok));
    store(lid + 9, 0, 3, 1, 1'b0, 1'b1, 30);
    check("total limit", 512'(0), 512'(ok));
    pulse(6, 0, 63);
    flush();
    settle();
    wrap_up();
  end
endmodule
